//--- core/bcr_consts.svh
// constants of the barometer command readout block
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
`define BCR_SLAVE_ADDR   7'h6D
`define BCR_PTR_RESULT   8'h06
`define BCR_PTR_COMMAND  8'h30
`define BCR_CMD_MEASURE  8'h0A
`define BCR_RESULT_BYTES 3'h5
`define BCR_CLK_MHZ      100
`define BCR_MEAS_TIME_US 5000
// two conversions share the measurement time
`define BCR_CONV_CYCLES  ((`BCR_MEAS_TIME_US * `BCR_CLK_MHZ) / 2)
`endif

//--- core/bcr_pkg.sv
// types of the barometer command readout block
package bcr_pkg;
    typedef struct packed {
        logic [23:0] press;
        logic [15:0] temp;
    } bcr_result_t;
    typedef enum logic [2:0] {
        BCR_BUS_IDLE, BCR_BUS_ADDR, BCR_BUS_ACK, BCR_BUS_WRB,
        BCR_BUS_RDB, BCR_BUS_RACK, BCR_BUS_SKIP
    } bcr_bus_st_t;
    typedef enum logic [1:0] {
        BCR_M_SLEEP, BCR_M_PRESS, BCR_M_TEMP, BCR_M_STORE
    } bcr_meas_st_t;
endpackage

//--- core/bcr_sync.sv
// two-stage synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module bcr_sync (
    input  wire logic ref_clk_in,  // block clock
    input  wire logic srst_in,     // sync reset, high
    input  wire logic d_in,        // asynchronous pin
    output logic      q_out        // synchronised level
);
    logic meta_q;
    logic q_q;
    // reset to released bus level so no false start after reset
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            meta_q <= 1'b1;
            q_q    <= 1'b1;
        end else begin
            meta_q <= d_in;
            q_q    <= meta_q;
        end
    end
    assign q_out = q_q;
endmodule
`default_nettype wire

//--- core/bcr_top.sv
// two-wire command and readout logic of the barometer
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"
// What this block does
// RQ1: sleeps after reset until measurement request
// RQ2: request wakes, measures, stores, sleeps again
// RQ3: answers only slave address 0x6D
// RQ4: reads never start a measurement
// RQ5: snapshot loaded after read address
// RQ6: results big-endian, most significant first
// RQ7: read address acknowledged, then data bytes
// RQ8: master ends read with nack, stop
// RQ9: pointer 0x06, re-address, five result bytes
// RQ10: master may stop after pressure bytes
// RQ11: temperature 16-bit two's complement, high first
// RQ12: pressure 24-bit unsigned, high byte first
// RQ13: request is pointer 0x30 then 0x0A
// RQ14: master stops after request acknowledged
// RQ15: pressure converted before temperature, then stored
// RQ16: master spaces requests by 5 ms
// RQ17: sensor powered only during conversion
// RQ18: other pointers or commands acked, ignored
module bcr_top #(
    parameter int CONV_CYCLES = `BCR_CONV_CYCLES
) (
    input  wire logic        ref_clk_in,     // 100 MHz block clock
    input  wire logic        srst_in,        // sync reset, high
    input  wire logic        scl_in,         // bus clock pin
    input  wire logic        sda_in,         // bus data pin level
    output logic             sda_out,        // bus data drive level
    output logic             sda_oe_n_out,   // low while driving data
    input  wire logic [23:0] adc_press_in,   // compensated pressure
    input  wire logic [15:0] adc_temp_in,    // compensated temperature
    output logic             sensor_pwr_out, // sensing element supply
    output logic             conv_temp_out,  // high during temperature phase
    output logic             busy_out        // measurement running
);
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    bcr_sync u_scl_sync (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .d_in       (scl_in),
        .q_out      (scl_s)
    );
    bcr_sync u_sda_sync (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .d_in       (sda_in),
        .q_out      (sda_s)
    );

    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // bus side state
    bcr_pkg::bcr_bus_st_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        rw_q, rw_d;
    logic        wfirst_q, wfirst_d;
    logic        oe_n_q, oe_n_d;
    logic [39:0] tx_q, tx_d;
    logic        ld_rd;
    logic        meas_req;
    logic        cmd_byte;

    // measurement side state
    bcr_pkg::bcr_meas_st_t m_st_q, m_st_d;
    logic [31:0]          m_cnt_q, m_cnt_d;
    logic [23:0]          p_hold_q, p_hold_d;
    bcr_pkg::bcr_result_t res_q, res_d;
    logic                 pwr_q, pwr_d;
    logic                 meas_go;
    logic                 conv_done;

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        sh_d     = sh_q;
        ptr_d    = ptr_q;
        rw_d     = rw_q;
        wfirst_d = wfirst_q;
        oe_n_d   = oe_n_q;
        tx_d     = tx_q;
        ld_rd    = 1'b0;
        meas_req = 1'b0;
        cmd_byte = 1'b0;
        if (bus_stop) begin
            st_d   = bcr_pkg::BCR_BUS_IDLE;
            oe_n_d = 1'b1;
        end else if (bus_start) begin
            st_d   = bcr_pkg::BCR_BUS_ADDR;
            cnt_d  = 4'h0;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                bcr_pkg::BCR_BUS_ADDR, bcr_pkg::BCR_BUS_WRB: begin
                    if (scl_rise && cnt_q != 4'h8) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        st_d   = bcr_pkg::BCR_BUS_ACK;
                        oe_n_d = 1'b0;
                        if (st_q == bcr_pkg::BCR_BUS_ADDR) begin
                            if (sh_q[7:1] == `BCR_SLAVE_ADDR) begin // RQ3
                                rw_d     = sh_q[0];
                                wfirst_d = 1'b1;
                                if (sh_q[0]) begin
                                    ld_rd = 1'b1;
                                    tx_d  = res_q; // RQ5
                                end
                            end else begin
                                st_d   = bcr_pkg::BCR_BUS_SKIP; // RQ3
                                oe_n_d = 1'b1;
                            end
                        end else if (wfirst_q) begin
                            ptr_d    = sh_q; // RQ9
                            wfirst_d = 1'b0;
                        end else begin
                            cmd_byte = 1'b1;
                            // only the measure code at the command pointer acts
                            meas_req = (ptr_q == `BCR_PTR_COMMAND) &&
                                       (sh_q == `BCR_CMD_MEASURE); // RQ13 RQ18
                        end
                    end
                end
                bcr_pkg::BCR_BUS_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            st_d   = bcr_pkg::BCR_BUS_RDB; // RQ7
                            oe_n_d = tx_q[39]; // RQ6
                        end else begin
                            st_d   = bcr_pkg::BCR_BUS_WRB;
                            oe_n_d = 1'b1;
                        end
                    end
                end
                bcr_pkg::BCR_BUS_RDB: begin
                    if (scl_fall) begin
                        // released bus past the packet reads as all ones
                        tx_d = {tx_q[38:0], 1'b1}; // RQ6 RQ11 RQ12
                        if (cnt_q == 4'h7) begin
                            st_d   = bcr_pkg::BCR_BUS_RACK;
                            oe_n_d = 1'b1;
                        end else begin
                            cnt_d  = cnt_q + 4'h1;
                            oe_n_d = tx_q[38];
                        end
                    end
                end
                bcr_pkg::BCR_BUS_RACK: begin
                    if (scl_rise && sda_s) begin
                        st_d = bcr_pkg::BCR_BUS_SKIP; // RQ8 RQ10
                    end else if (scl_fall) begin
                        st_d   = bcr_pkg::BCR_BUS_RDB;
                        cnt_d  = 4'h0;
                        oe_n_d = tx_q[39];
                    end
                end
                bcr_pkg::BCR_BUS_IDLE, bcr_pkg::BCR_BUS_SKIP: begin
                    oe_n_d = 1'b1;
                end
                default: begin
                    st_d   = bcr_pkg::BCR_BUS_IDLE;
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
            st_q     <= bcr_pkg::BCR_BUS_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            ptr_q    <= 8'h00;
            rw_q     <= 1'b0;
            wfirst_q <= 1'b0;
            oe_n_q   <= 1'b1;
            tx_q     <= 40'h0;
        end else begin
            scl_p_q  <= scl_s;
            sda_p_q  <= sda_s;
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            ptr_q    <= ptr_d;
            rw_q     <= rw_d;
            wfirst_q <= wfirst_d;
            oe_n_q   <= oe_n_d;
            tx_q     <= tx_d;
        end
    end

    // a request during a running cycle is dropped; spacing is the master's job
    assign meas_go   = meas_req && m_st_q == bcr_pkg::BCR_M_SLEEP; // RQ1 RQ2
    assign conv_done = m_cnt_q == 32'(CONV_CYCLES - 1);

    always_comb begin
        m_st_d   = m_st_q;
        m_cnt_d  = m_cnt_q;
        p_hold_d = p_hold_q;
        res_d    = res_q;
        case (m_st_q)
            bcr_pkg::BCR_M_SLEEP: begin
                m_cnt_d = 32'h0;
                if (meas_go) begin
                    m_st_d = bcr_pkg::BCR_M_PRESS; // RQ2
                end
            end
            bcr_pkg::BCR_M_PRESS: begin
                m_cnt_d = m_cnt_q + 32'h1;
                if (conv_done) begin
                    p_hold_d = adc_press_in;
                    m_cnt_d  = 32'h0;
                    m_st_d   = bcr_pkg::BCR_M_TEMP; // RQ15
                end
            end
            bcr_pkg::BCR_M_TEMP: begin
                m_cnt_d = m_cnt_q + 32'h1;
                if (conv_done) begin
                    m_st_d = bcr_pkg::BCR_M_STORE;
                end
            end
            bcr_pkg::BCR_M_STORE: begin
                // both values land together so a snapshot never mixes cycles
                res_d.press = p_hold_q; // RQ15
                res_d.temp  = adc_temp_in;
                m_st_d      = bcr_pkg::BCR_M_SLEEP; // RQ2
            end
            default: begin
                m_st_d = bcr_pkg::BCR_M_SLEEP;
            end
        endcase
        pwr_d = m_st_d == bcr_pkg::BCR_M_PRESS ||
                m_st_d == bcr_pkg::BCR_M_TEMP; // RQ17
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            m_st_q   <= bcr_pkg::BCR_M_SLEEP; // RQ1
            m_cnt_q  <= 32'h0;
            p_hold_q <= 24'h0;
            res_q    <= '0;
            pwr_q    <= 1'b0;
        end else begin
            m_st_q   <= m_st_d;
            m_cnt_q  <= m_cnt_d;
            p_hold_q <= p_hold_d;
            res_q    <= res_d;
            pwr_q    <= pwr_d;
        end
    end

    logic sda_lvl_q, temp_q, busy_q;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sda_lvl_q <= 1'b0;
            temp_q    <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            sda_lvl_q <= 1'b0;
            temp_q    <= m_st_d == bcr_pkg::BCR_M_TEMP;
            busy_q    <= m_st_d != bcr_pkg::BCR_M_SLEEP;
        end
    end

    assign sda_out        = sda_lvl_q;
    assign sda_oe_n_out   = oe_n_q;
    assign sensor_pwr_out = pwr_q;
    assign conv_temp_out  = temp_q;
    assign busy_out       = busy_q;

    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    wake_on_req_a: assert property (meas_go |=> sensor_pwr_out && !conv_temp_out) // RQ2
        else $error("request did not wake the sensor");
    back_to_sleep_a: assert property (m_st_q == bcr_pkg::BCR_M_STORE |=> // RQ2
        !busy_out && !sensor_pwr_out && m_st_q == bcr_pkg::BCR_M_SLEEP)
        else $error("device did not return to sleep");
    sleep_idle_a: assert property (m_st_q == bcr_pkg::BCR_M_SLEEP && !meas_go // RQ1
        |=> m_st_q == bcr_pkg::BCR_M_SLEEP && !sensor_pwr_out)
        else $error("left sleep without a request");
    addr_filter_a: assert property (st_q == bcr_pkg::BCR_BUS_ADDR && scl_fall && // RQ3
        cnt_q == 4'h8 && !bus_stop && !bus_start && sh_q[7:1] != `BCR_SLAVE_ADDR
        |=> sda_oe_n_out && st_q == bcr_pkg::BCR_BUS_SKIP)
        else $error("foreign address acknowledged");
    result_stable_a: assert property (m_st_q != bcr_pkg::BCR_M_STORE |=> $stable(res_q)) // RQ4
        else $error("results changed without a measurement");
    snapshot_load_a: assert property (ld_rd |=> tx_q == $past(res_q) && !sda_oe_n_out) // RQ5
        else $error("read snapshot or address ack wrong");
    msb_first_a: assert property (st_q == bcr_pkg::BCR_BUS_RDB |-> sda_oe_n_out == tx_q[39]) // RQ6
        else $error("data bit not taken from top of snapshot");
    press_first_a: assert property (m_st_q == bcr_pkg::BCR_M_PRESS && conv_done // RQ15
        |=> m_st_q == bcr_pkg::BCR_M_TEMP ##1 conv_temp_out)
        else $error("temperature did not follow pressure");
    pwr_conv_a: assert property (sensor_pwr_out |-> // RQ17
        m_st_q == bcr_pkg::BCR_M_PRESS || m_st_q == bcr_pkg::BCR_M_TEMP)
        else $error("sensor powered outside a conversion");
    bad_cmd_a: assert property (cmd_byte && (ptr_q != `BCR_PTR_COMMAND || // RQ18
        sh_q != `BCR_CMD_MEASURE) |-> !meas_go ##1 !sda_oe_n_out)
        else $error("ignored command mishandled");
endmodule
`default_nettype wire

//--- test/bcr_master.sv
// two-wire bus master model that commands and reads the barometer block
`timescale 1ns/1ps
`default_nettype none
module bcr_master (
    input  wire logic sda_in,   // resolved data wire level
    output logic      scl_out,  // bus clock, idle high between frames
    output logic      sda_out   // data drive, 1 releases to pull-up
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // callers align to a falling block clock edge; all steps are 10 ns multiples
    task automatic start();
        sda_out = 1'b1;
        #30 scl_out = 1'b1;
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b0;
    endtask

    task automatic stop();
        sda_out = 1'b0;
        #30 scl_out = 1'b1;
        #40 sda_out = 1'b1;
        #40;
    endtask

    // long low phase leaves room for the slave's synchroniser latency
    task automatic xfer_bit(input logic b, output logic r);
        #30 sda_out = b;
        #30 scl_out = 1'b1;
        #10 r = sda_in;
        #10 scl_out = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(last, r);
    endtask

    task automatic wr_cmd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v,
                          output logic [2:0] acks);
        start();
        wr_byte(a, acks[2]);
        wr_byte(p, acks[1]);
        wr_byte(v, acks[0]);
        stop();
    endtask

    task automatic read_pkt(input int n, output logic [39:0] pkt, output logic [2:0] acks);
        logic [7:0] d;
        pkt = '1;
        start();
        wr_byte(8'hDA, acks[2]);
        wr_byte(8'h06, acks[1]);
        start();
        wr_byte(8'hDB, acks[0]);
        for (int k = 0; k < n; k++) begin
            rd_byte(k == n - 1, d);
            pkt[39 - 8 * k -: 8] = d;
        end
        stop();
    endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench of the barometer command readout block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CONV = 200;
    logic        ref_clk_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic        scl, m_sda, sda, sda_o, sda_oe_n, pwr, conv_t, busy;
    logic [23:0] adc_press  = 24'h000000;
    logic [15:0] adc_temp   = 16'h0000;
    logic [39:0] pkt;
    logic [2:0]  acks;
    int          err_count  = 0;
    int          n_tests    = 0;
    int          p_cnt      = 0;
    int          t_cnt      = 0;
    int          p_base     = 0;
    int          t_base     = 0;

    always #5 ref_clk_in = ~ref_clk_in;
    // open drain wire with pull-up
    assign sda = m_sda & (sda_oe_n ? 1'b1 : sda_o);

    always @(posedge ref_clk_in) begin
        if (pwr === 1'b1 && conv_t === 1'b0) p_cnt++;
        if (pwr === 1'b1 && conv_t === 1'b1) t_cnt++;
    end

    bcr_top #(.CONV_CYCLES(CONV)) u_bcr_top (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .scl_in         (scl),
        .sda_in         (sda),
        .sda_out        (sda_o),
        .sda_oe_n_out   (sda_oe_n),
        .adc_press_in   (adc_press),
        .adc_temp_in    (adc_temp),
        .sensor_pwr_out (pwr),
        .conv_temp_out  (conv_t),
        .busy_out       (busy)
    );

    bcr_master u_bcr_master (
        .sda_in  (sda),
        .scl_out (scl),
        .sda_out (m_sda)
    );

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // sel 0 waits on busy, sel 1 on the temperature phase flag
    task automatic wait_lvl(input int sel, input logic lvl);
        int i;
        for (i = 0; i < 1000 && (sel ? conv_t : busy) !== lvl; i++) @(negedge ref_clk_in);
        if (i == 1000) begin
            err_count++;
            $display("[FAIL] %0t wait on status flag timed out", $time);
            end_sim();
        end
    endtask

    initial begin
        repeat (4) @(negedge ref_clk_in);
        srst_in = 1'b0;
        repeat (6) @(negedge ref_clk_in);
        check({pwr, conv_t, busy, sda_oe_n}, 4'b0001, "idle after reset");
        adc_press = 24'h5A3C1F;
        adc_temp  = 16'h7FFF;
        u_bcr_master.read_pkt(5, pkt, acks);
        check(acks, 3'b111, "read acks");
        check(pkt, 40'h0, "read before measure");
        check({pwr, busy}, 2'b00, "read stays asleep");
        $display("test read before measure done");

        u_bcr_master.wr_cmd(8'hD8, 8'h30, 8'h0A, acks);
        check(acks, 3'b000, "foreign address");
        u_bcr_master.wr_cmd(8'hDA, 8'h31, 8'h0A, acks);
        check(acks, 3'b111, "other pointer acks");
        u_bcr_master.wr_cmd(8'hDA, 8'h30, 8'h0B, acks);
        check(acks, 3'b111, "other code acks");
        repeat (5) @(negedge ref_clk_in);
        check({pwr, busy}, 2'b00, "ignored writes");
        $display("test ignored transfers done");

        // temperature input is junk in the pressure phase and the reverse later
        // the counters have one writer; the test measures from a baseline
        p_base = p_cnt;
        t_base = t_cnt;
        u_bcr_master.wr_cmd(8'hDA, 8'h30, 8'h0A, acks);
        check(acks, 3'b111, "request acks");
        check({pwr, conv_t, busy}, 3'b101, "woken in pressure phase");
        wait_lvl(1, 1'b1);
        adc_press = 24'hFFFFFF;
        adc_temp  = 16'hFE80;
        wait_lvl(0, 1'b0);
        check(pwr, 1'b0, "sensor off after cycle");
        check(p_cnt - p_base >= CONV - 1 && p_cnt - p_base <= CONV + 1, 1'b1, "press len");
        check(t_cnt - t_base >= CONV - 1 && t_cnt - t_base <= CONV + 1, 1'b1, "temp len");
        u_bcr_master.read_pkt(5, pkt, acks);
        check(pkt, {24'h5A3C1F, 16'hFE80}, "stored packet");
        $display("test measurement done");

        u_bcr_master.read_pkt(3, pkt, acks);
        check(pkt[39:16], 24'h5A3C1F, "pressure only read");
        u_bcr_master.read_pkt(5, pkt, acks);
        check(pkt, {24'h5A3C1F, 16'hFE80}, "repeat read same");
        $display("test repeated reads done");

        repeat (2 * CONV + 2) @(negedge ref_clk_in);
        adc_press = 24'h012345;
        adc_temp  = 16'h0C80;
        u_bcr_master.wr_cmd(8'hDA, 8'h30, 8'h0A, acks);
        // the store lands while this read is shifting out
        u_bcr_master.read_pkt(5, pkt, acks);
        check(pkt, {24'h5A3C1F, 16'hFE80}, "snapshot held");
        check(busy, 1'b0, "back asleep");
        u_bcr_master.read_pkt(5, pkt, acks);
        check(pkt, {24'h012345, 16'h0C80}, "refreshed packet");
        $display("test snapshot done");
        end_sim();
    end
endmodule
`default_nettype wire
